/* File: pkg/stsv_pkg.sv */
// Purpose: Shared constants and types of the supply and thermal supervisor.
// Assumes: One 50 MHz clock; comparator levels arrive asynchronously.
// Notes:   Times are kept in microseconds, cycle counts derive from them.
// How it works
// - Short detection on the main supply is armed only without battery undervoltage.
// - Main supply not up within filter after power-up or wake: short reaction, Fail-Safe.
// - Main supply low longer than the filter during operation gives the same reaction.
// - After a short Fail-Safe, bus, wake pin or configured GPIO wake restarts.
// - Aux undervoltage while enabled sets a sticky flag cleared by software.
// - Aux undervoltage flag is blanked after switch-on and while switching.
// - Transceiver supply undervoltage while enabled sets a software-cleared flag.
// - Aux overheat switches the aux stage off, transceiver overheat its transmitter; both set block flag.
// - Per-block thermal shutdown is evaluated only while that block is on.
// - Aux overheat clears its enable and sets its flag; software re-enables.
// - Transceiver overheat stops transmit only, code 01, transmit returns when cool.
// - Thermal flags never self-clear; software clears them after the heat ends.
// - Main stage prewarning sets a flag clearable only once the heat is gone.
// - Chip overheat enters Fail-Safe; cool-down wait starts once temperature drops.
// - Cool-down expiry moves through Restart into Normal automatically.
// - Chip overheat flag clears only in Normal and only after heat has ended.
// - With extension enabled, 16 events lengthen cool-down to 64 times.
// - Event counter increments on each chip overheat up to 16, even with flag uncleared.
// - Reaching 16 events with extension enabled sets the safe flag; extended wait holds until cleared.
// - Clearing chip overheat flag or extension enable resets the event counter.
// - Chip overheat while entering Sleep enters Fail-Safe instead.
// - Threshold raise setting lifts block and chip shutdown thresholds by 10 K.
// - Short filter is 2 ms, used as power-up blanking and short duration.
// - Aux undervoltage blanking after switch-on is 4 ms.
`default_nettype none
package stsv_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned SHORT_FILTER_US = 2000;
   localparam int unsigned AUX_BLANK_US = 4000;
   localparam int unsigned COOLDOWN_US = 1000;
   localparam int unsigned SHORT_CYC = SHORT_FILTER_US * CYC_PER_US;
   localparam int unsigned AUX_BLANK_CYC = AUX_BLANK_US * CYC_PER_US;
   localparam int unsigned COOLDOWN_CYC = COOLDOWN_US * CYC_PER_US;
   localparam int unsigned EXTEND_MULT = 64;
   localparam int unsigned TIMER_W = 32;
   localparam logic [4:0] EVENT_LIMIT = 5'h10;
   localparam logic [1:0] XCVR_FAULT_NONE = 2'h0;
   localparam logic [1:0] XCVR_FAULT_OT = 2'h1;
   localparam int unsigned THR_RAISE_K = 10;

   typedef enum logic [3:0] {
      STSV_RESTART = 4'h1,
      STSV_NORMAL = 4'h2,
      STSV_SLEEP = 4'h4,
      STSV_FAILSAFE = 4'h8
   } stsv_mode_t;

   typedef struct packed {
      logic vs_uv;
      logic main_supply_low;
      logic aux_uv;
      logic xcvr_uv;
      logic aux_hot;
      logic xcvr_hot;
      logic prewarn_hot;
      logic chip_hot;
      logic wake_bus;
      logic wake_pin;
      logic wake_gpio;
   } stsv_sense_t;

   typedef struct packed {
      logic main_supply_short;
      logic flag_a;
      logic aux_uv;
      logic xcvr_uv;
      logic block_ot;
      logic aux_ot;
      logic xcvr_fault;
      logic prewarn;
      logic chip_ot;
      logic safe;
   } stsv_clr_t;

   typedef struct packed {
      logic main_supply_short;
      logic flag_a;
      logic aux_uv;
      logic xcvr_uv;
      logic block_ot;
      logic aux_ot;
      logic prewarn;
      logic chip_ot;
      logic safe;
      logic [1:0] xcvr_fault;
   } stsv_flags_t;
endpackage : stsv_pkg
`default_nettype wire

/* File: rtl/stsv_timer.sv */
// Purpose: Interval counter that saturates at its limit.
// Assumes: Limit is stable while running.
// Notes:   Dropping run restarts the count from zero on the next edge.
`default_nettype none
module stsv_timer #(
   parameter int unsigned W = 32
) (
   input wire logic clock_i, // System clock.
   input wire logic rst_i, // Asynchronous reset, active high.
   input wire logic run_i, // Qualifying condition present.
   input wire logic [W-1:0] limit_i, // Cycles to reach.
   output logic done_o // Condition held for the limit.
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (!run_i) begin
         cnt_q <= '0;
      end else if (cnt_q < limit_i) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   assign done_o = run_i && (cnt_q >= limit_i);
endmodule : stsv_timer
`default_nettype wire

/* File: rtl/stsv_supervisor.sv */
// Purpose: Supply short, undervoltage and thermal supervision with mode control.
// Assumes: Sense inputs are raw comparator levels; software strobes are one cycle.
// Notes:   Reset delay and analog thresholds live outside this block.
`default_nettype none
module stsv_supervisor #(
   parameter int unsigned SHORT_CYC = stsv_pkg::SHORT_CYC,
   parameter int unsigned AUX_BLANK_CYC = stsv_pkg::AUX_BLANK_CYC,
   parameter int unsigned COOLDOWN_CYC = stsv_pkg::COOLDOWN_CYC
) (
   input wire logic clock_i, // System clock, 50 MHz.
   input wire logic rst_i, // Power-on reset, asynchronous, active high.
   input wire stsv_pkg::stsv_sense_t sense_i, // Raw comparator and wake levels.
   input wire stsv_pkg::stsv_clr_t clr_i, // Software flag clear strobes.
   input wire logic gpio_wake_cfg_i, // GPIO configured as wake input.
   input wire logic aux_wr_i, // Software write of aux enable.
   input wire logic aux_wr_data_i, // Value written to aux enable.
   input wire logic xcvr_en_i, // Transceiver module enabled.
   input wire logic sleep_req_i, // Software request to enter Sleep.
   input wire logic overtemp_extend_en_i, // Extended cool-down enable.
   input wire logic overtemp_threshold_raise_i, // Raise thermal thresholds.
   output logic main_supply_en_o, // Main regulator on.
   output logic aux_supply_on_ctrl_o, // Aux regulator enable.
   output logic xcvr_tx_en_o, // Transmitter enabled.
   output logic fail_output_o, // Fail output active.
   output logic thr_raise_o, // Threshold raise to comparators.
   output stsv_pkg::stsv_mode_t mode_o, // Operating mode.
   output logic [4:0] event_cnt_o, // Chip overheat event count.
   output stsv_pkg::stsv_flags_t flags_o // Sticky status flags.
);
   // ******************************************************
   // Input synchronisation
   // ******************************************************
   localparam int unsigned SW = $bits(stsv_pkg::stsv_sense_t);
   logic [SW-1:0] meta_q;
   logic [SW-1:0] sync_q;
   stsv_pkg::stsv_sense_t s;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= sense_i;
         sync_q <= meta_q;
      end
   end
   assign s = stsv_pkg::stsv_sense_t'(sync_q);

   // A flag takes the event even in the cycle software clears it.
   function automatic logic sticky(input logic q, input logic set, input logic clr_ok);
      sticky = set | (q & ~clr_ok);
   endfunction : sticky

   // ******************************************************
   // Declarations
   // ******************************************************
   localparam int unsigned TW = stsv_pkg::TIMER_W;
   stsv_pkg::stsv_mode_t mode_q, mode_d;
   logic main_on_q, aux_on_q, tx_en_q, fail_q, fs_short_q, thr_q;
   logic chip_hot_q, ext_en_q;
   logic [4:0] cnt_q;
   logic vsc_q, fla_q, auv_q, xuv_q, bot_q, aot_q, pw_q, cot_q, safe_q;
   logic [1:0] xf_q;
   logic short_run, short_hit, blank_done, cool_run, cool_done;
   logic wake_any, aux_trip, xcvr_trip, chip_evt, cnt_clr, leave_to_restart;
   logic [TW-1:0] cool_lim;

   // ******************************************************
   // Interval timers
   // ******************************************************
   // Arm on battery good.
   assign short_run = main_on_q && !s.vs_uv && s.main_supply_low;

   stsv_timer #(.W(TW)) u_short (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .run_i(short_run),
      .limit_i(TW'(SHORT_CYC)),
      .done_o(short_hit)
   );

   stsv_timer #(.W(TW)) u_blank (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .run_i(aux_on_q),
      .limit_i(TW'(AUX_BLANK_CYC)),
      .done_o(blank_done)
   );

   assign cool_lim = safe_q ? TW'(COOLDOWN_CYC * stsv_pkg::EXTEND_MULT) : TW'(COOLDOWN_CYC);
   assign cool_run = (mode_q == stsv_pkg::STSV_FAILSAFE) && !fs_short_q && !s.chip_hot;

   stsv_timer #(.W(TW)) u_cool (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .run_i(cool_run),
      .limit_i(cool_lim),
      .done_o(cool_done)
   );

   // ******************************************************
   // Mode control
   // ******************************************************
   // Wake sources.
   assign wake_any = s.wake_bus || s.wake_pin || (s.wake_gpio && gpio_wake_cfg_i);
   assign chip_evt = s.chip_hot && !chip_hot_q;

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         stsv_pkg::STSV_RESTART: begin
            if (short_hit || s.chip_hot) begin
               mode_d = stsv_pkg::STSV_FAILSAFE;
            end else if (!s.main_supply_low) begin
               mode_d = stsv_pkg::STSV_NORMAL;
            end
         end
         stsv_pkg::STSV_NORMAL: begin
            if (short_hit || s.chip_hot) begin
               mode_d = stsv_pkg::STSV_FAILSAFE;
            end else if (sleep_req_i) begin
               mode_d = stsv_pkg::STSV_SLEEP;
            end
         end
         stsv_pkg::STSV_SLEEP: begin
            if (s.chip_hot) begin
               mode_d = stsv_pkg::STSV_FAILSAFE;
            end else if (wake_any) begin
               mode_d = stsv_pkg::STSV_RESTART;
            end
         end
         stsv_pkg::STSV_FAILSAFE: begin
            if (fs_short_q || short_hit) begin
               if (wake_any && !short_hit) begin
                  mode_d = stsv_pkg::STSV_RESTART;
               end
            end else if (cool_done) begin
               mode_d = stsv_pkg::STSV_RESTART;
            end
         end
         default: mode_d = stsv_pkg::STSV_FAILSAFE;
      endcase
   end

   assign leave_to_restart = (mode_d == stsv_pkg::STSV_RESTART) &&
                             (mode_q != stsv_pkg::STSV_RESTART);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= stsv_pkg::STSV_RESTART;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Short reaction on the main supply.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         main_on_q <= 1'b1;
         fs_short_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         if (leave_to_restart) begin
            main_on_q <= 1'b1;
         end else if (short_hit || mode_d == stsv_pkg::STSV_SLEEP) begin
            main_on_q <= 1'b0;
         end
         if (short_hit) begin
            fs_short_q <= 1'b1;
         end else if (leave_to_restart) begin
            fs_short_q <= 1'b0;
         end
         // Fail output holds until the device is back in Normal.
         if (short_hit || chip_evt) begin
            fail_q <= 1'b1;
         end else if (mode_q == stsv_pkg::STSV_NORMAL) begin
            fail_q <= 1'b0;
         end
      end
   end

   // ******************************************************
   // Block thermal and undervoltage
   // ******************************************************
   // Evaluated only while on.
   assign aux_trip = aux_on_q && s.aux_hot;
   assign xcvr_trip = xcvr_en_i && s.xcvr_hot;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         aux_on_q <= 1'b0;
      end else if (aux_trip) begin
         aux_on_q <= 1'b0;
      end else if (aux_wr_i) begin
         aux_on_q <= aux_wr_data_i;
      end
   end

   // Receive stays, transmit returns when cool.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tx_en_q <= 1'b0;
      end else begin
         tx_en_q <= xcvr_en_i && !s.xcvr_hot;
      end
   end

   // Thermal flags clear only when cool.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         bot_q <= 1'b0;
         aot_q <= 1'b0;
         xf_q <= stsv_pkg::XCVR_FAULT_NONE;
         pw_q <= 1'b0;
      end else begin
         bot_q <= sticky(bot_q, aux_trip | xcvr_trip,
                         clr_i.block_ot & ~s.aux_hot & ~s.xcvr_hot);
         aot_q <= sticky(aot_q, aux_trip, clr_i.aux_ot & ~s.aux_hot);
         if (xcvr_trip) begin
            xf_q <= stsv_pkg::XCVR_FAULT_OT;
         end else if (clr_i.xcvr_fault && !s.xcvr_hot) begin
            xf_q <= stsv_pkg::XCVR_FAULT_NONE;
         end
         pw_q <= sticky(pw_q, s.prewarn_hot, clr_i.prewarn & ~s.prewarn_hot);
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         auv_q <= 1'b0;
         xuv_q <= 1'b0;
      end else begin
         auv_q <= sticky(auv_q, aux_on_q & blank_done & ~aux_wr_i & s.aux_uv, clr_i.aux_uv);
         xuv_q <= sticky(xuv_q, xcvr_en_i & s.xcvr_uv, clr_i.xcvr_uv);
      end
   end

   // Short flags from the same filter.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         vsc_q <= 1'b0;
         fla_q <= 1'b0;
      end else begin
         vsc_q <= sticky(vsc_q, short_hit, clr_i.main_supply_short);
         fla_q <= sticky(fla_q, short_hit, clr_i.flag_a);
      end
   end

   // ******************************************************
   // Chip overheat events
   // ******************************************************
   // Counter reset on either clear.
   assign cnt_clr = (clr_i.chip_ot && mode_q == stsv_pkg::STSV_NORMAL && !s.chip_hot) ||
                    (ext_en_q && !overtemp_extend_en_i);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         chip_hot_q <= 1'b0;
         ext_en_q <= 1'b0;
         thr_q <= 1'b0;
         cot_q <= 1'b0;
         cnt_q <= '0;
         safe_q <= 1'b0;
      end else begin
         chip_hot_q <= s.chip_hot;
         ext_en_q <= overtemp_extend_en_i;
         thr_q <= overtemp_threshold_raise_i;
         // Clear only in Normal when cool.
         cot_q <= sticky(cot_q, chip_evt,
                         clr_i.chip_ot & (mode_q == stsv_pkg::STSV_NORMAL) & ~s.chip_hot);
         if (chip_evt) begin
            if (cnt_clr) begin
               cnt_q <= 5'h01;
            end else if (cnt_q != stsv_pkg::EVENT_LIMIT) begin
               cnt_q <= cnt_q + 5'h01;
            end
         end else if (cnt_clr) begin
            cnt_q <= '0;
         end
         safe_q <= sticky(safe_q, chip_evt & overtemp_extend_en_i & ~cnt_clr &
                          (cnt_q == stsv_pkg::EVENT_LIMIT - 5'h01), clr_i.safe);
      end
   end

   // ******************************************************
   // Outputs
   // ******************************************************
   assign main_supply_en_o = main_on_q;
   assign aux_supply_on_ctrl_o = aux_on_q;
   assign xcvr_tx_en_o = tx_en_q;
   assign fail_output_o = fail_q;
   assign thr_raise_o = thr_q;
   assign mode_o = mode_q;
   assign event_cnt_o = cnt_q;
   assign flags_o = '{main_supply_short: vsc_q, flag_a: fla_q, aux_uv: auv_q, xcvr_uv: xuv_q,
                      block_ot: bot_q, aux_ot: aot_q, prewarn: pw_q, chip_ot: cot_q,
                      safe: safe_q, xcvr_fault: xf_q};

   // ******************************************************
   // Checks
   // ******************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence short_seen;
      short_hit ##1 1'b1;
   endsequence

   short_react_a: assert property (short_seen |-> !main_supply_en_o && flags_o.main_supply_short
      && flags_o.flag_a && fail_output_o && mode_o == stsv_pkg::STSV_FAILSAFE)
      else $error("short reaction incomplete");
   short_arm_a: assert property (s.vs_uv |=> !short_hit)
      else $error("short detect armed under battery undervoltage");
   aux_trip_a: assert property (aux_trip |=> !aux_supply_on_ctrl_o && flags_o.aux_ot
      && flags_o.block_ot)
      else $error("aux overheat reaction missing");
   xcvr_code_a: assert property (xcvr_trip
      |=> flags_o.xcvr_fault == stsv_pkg::XCVR_FAULT_OT && !xcvr_tx_en_o)
      else $error("transceiver fault code wrong");
   prewarn_hold_a: assert property (s.prewarn_hot ##1 s.prewarn_hot |-> flags_o.prewarn)
      else $error("prewarning flag lost while hot");
   chip_hold_a: assert property ($rose(flags_o.chip_ot) ##1
      (mode_o != stsv_pkg::STSV_NORMAL) |-> flags_o.chip_ot)
      else $error("chip flag cleared outside Normal");
   sleep_block_a: assert property (mode_o == stsv_pkg::STSV_NORMAL && s.chip_hot
      |=> mode_o == stsv_pkg::STSV_FAILSAFE)
      else $error("overheat did not force Fail-Safe");
   count_up_a: assert property (chip_evt && !cnt_clr && cnt_q < 5'h10
      |=> event_cnt_o == $past(cnt_q) + 5'h01)
      else $error("event counter did not advance");
   count_clr_a: assert property (cnt_clr && !chip_evt |=> event_cnt_o == 5'h00)
      else $error("event counter not reset");
   cool_exit_a: assert property (cool_done && !short_hit && mode_o == stsv_pkg::STSV_FAILSAFE
      |=> mode_o == stsv_pkg::STSV_RESTART)
      else $error("cool-down expiry ignored");
endmodule : stsv_supervisor
`default_nettype wire

/* File: verification/stsv_sw_model.sv */
// Purpose: Software model that issues flag clears and aux enable writes.
// Assumes: The bench calls its tasks between clock edges.
// Notes:   Each request becomes a one-cycle strobe, as one serial write would.
`default_nettype none
module stsv_sw_model (
   input wire logic clock_i, // System clock.
   output stsv_pkg::stsv_clr_t clr_o, // Flag clear strobes.
   output logic aux_wr_o, // Aux enable write strobe.
   output logic aux_wr_data_o // Aux enable value.
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      clr_o = '0;
      aux_wr_o = 1'b0;
      aux_wr_data_o = 1'b0;
   end

   // ****************************************
   // Software accesses
   // ****************************************
   // software flag clear
   task automatic clear(input stsv_pkg::stsv_clr_t m, input int lag);
      repeat (lag + 1) @(negedge clock_i);
      clr_o = m;
      @(negedge clock_i);
      clr_o = '0;
   endtask : clear

   task automatic write_aux(input logic v);
      @(negedge clock_i);
      aux_wr_o = 1'b1;
      aux_wr_data_o = v;
      @(negedge clock_i);
      aux_wr_o = 1'b0;
      aux_wr_data_o = ~v;
   endtask : write_aux
endmodule : stsv_sw_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench of the supply and thermal supervisor.
// Assumes: Inputs change on the falling edge; short intervals set by parameters.
// Notes:   Waits on mode changes are bounded; a watchdog ends a hang.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   stsv_pkg::stsv_sense_t sense = '0;
   stsv_pkg::stsv_clr_t clr;
   stsv_pkg::stsv_clr_t cm;
   logic aux_wr, aux_wd, main_en, aux_on, tx_en, fail_o, thr_o;
   logic gpio_cfg = 1'b0, xcvr_en = 1'b0, sleep_req = 1'b0, ext_en = 1'b0, thr = 1'b0;
   stsv_pkg::stsv_mode_t mode;
   logic [4:0] cnt;
   stsv_pkg::stsv_flags_t fl;
   int n_errors = 0;
   int comparisons = 0;
   int i;
   logic [31:0] seed = 32'h49fa;

   always #10 clock_i = ~clock_i;

   stsv_supervisor #(.SHORT_CYC(20), .AUX_BLANK_CYC(30), .COOLDOWN_CYC(10)) uut (
      .clock_i(clock_i), .rst_i(rst_i), .sense_i(sense), .clr_i(clr),
      .gpio_wake_cfg_i(gpio_cfg), .aux_wr_i(aux_wr), .aux_wr_data_i(aux_wd),
      .xcvr_en_i(xcvr_en), .sleep_req_i(sleep_req), .overtemp_extend_en_i(ext_en),
      .overtemp_threshold_raise_i(thr), .main_supply_en_o(main_en),
      .aux_supply_on_ctrl_o(aux_on), .xcvr_tx_en_o(tx_en), .fail_output_o(fail_o),
      .thr_raise_o(thr_o), .mode_o(mode), .event_cnt_o(cnt), .flags_o(fl));

   stsv_sw_model sw (.clock_i(clock_i), .clr_o(clr), .aux_wr_o(aux_wr),
      .aux_wr_data_o(aux_wd));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc

   task automatic wait_mode(input stsv_pkg::stsv_mode_t m, input int lim);
      int k;
      k = 0;
      while (mode !== m && k < lim) begin
         @(negedge clock_i);
         k++;
      end
      check("mode", 32'(mode), 32'(m));
   endtask : wait_mode

   task automatic clear_now(input stsv_pkg::stsv_clr_t m);
      sw.clear(m, int'(rnd() % 3));
      cyc(2);
   endtask : clear_now

   task automatic close_out();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   initial begin
      cyc(20000);
      n_errors++;
      close_out();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      cyc(11);
      check("reset mode", 32'(mode), 32'(stsv_pkg::STSV_RESTART));
      check("reset main", 32'(main_en), 32'h1);
      cyc(1);
      rst_i = 1'b0;
      wait_mode(stsv_pkg::STSV_NORMAL, 40);
      thr = 1'b1;
      cyc(3);
      check("thr raise", 32'(thr_o), 32'h1);
      for (i = 0; i < 4; i++) begin
         sense.main_supply_low = 1'b1;
         cyc(1 + int'(rnd() % 15));
         sense.main_supply_low = 1'b0;
         cyc(5);
      end
      check("glitch short", 32'(fl.main_supply_short), 32'h0);
      sense.vs_uv = 1'b1;
      sense.main_supply_low = 1'b1;
      cyc(40);
      check("uv short", 32'(fl.main_supply_short), 32'h0);
      sense.vs_uv = 1'b0;
      cyc(30);
      check("short flag", 32'(fl.main_supply_short), 32'h1);
      check("flag_a", 32'(fl.flag_a), 32'h1);
      check("fail out", 32'(fail_o), 32'h1);
      check("main off", 32'(main_en), 32'h0);
      check("short mode", 32'(mode), 32'(stsv_pkg::STSV_FAILSAFE));
      sense.wake_gpio = 1'b1;
      cyc(6);
      check("gpio no cfg", 32'(mode), 32'(stsv_pkg::STSV_FAILSAFE));
      sense.wake_gpio = 1'b0;
      cyc(3);
      gpio_cfg = 1'b1;
      cyc(2);
      for (i = 0; i < 3; i++) begin
         if (i == 2) sense.main_supply_low = 1'b0;
         {sense.wake_bus, sense.wake_pin, sense.wake_gpio} = 3'h4 >> i;
         wait_mode(stsv_pkg::STSV_RESTART, 10);
         check("wake main", 32'(main_en), 32'h1);
         {sense.wake_bus, sense.wake_pin, sense.wake_gpio} = 3'h0;
         if (i < 2) begin
            cyc(30);
            check("wake short", 32'(mode), 32'(stsv_pkg::STSV_FAILSAFE));
         end
      end
      wait_mode(stsv_pkg::STSV_NORMAL, 40);
      cm = '0;
      cm.main_supply_short = 1'b1;
      cm.flag_a = 1'b1;
      clear_now(cm);
      check("short clr", 32'({fl.main_supply_short, fl.flag_a, fail_o}), 32'h0);
      sw.write_aux(1'b1);
      sense.aux_uv = 1'b1;
      cyc(15);
      check("aux blank", 32'(fl.aux_uv), 32'h0);
      cyc(30);
      check("aux uv", 32'(fl.aux_uv), 32'h1);
      sense.aux_uv = 1'b0;
      cyc(4);
      check("aux uv kept", 32'(fl.aux_uv), 32'h1);
      cm = '0;
      cm.aux_uv = 1'b1;
      clear_now(cm);
      check("aux uv clr", 32'(fl.aux_uv), 32'h0);
      sense.aux_hot = 1'b1;
      cyc(5);
      check("aux ot off", 32'({aux_on, fl.aux_ot, fl.block_ot}), 32'h3);
      cm = '0;
      cm.block_ot = 1'b1;
      cm.aux_ot = 1'b1;
      clear_now(cm);
      check("hot clr", 32'({fl.aux_ot, fl.block_ot}), 32'h3);
      sense.aux_hot = 1'b0;
      cyc(5);
      check("aux stays off", 32'(aux_on), 32'h0);
      clear_now(cm);
      check("cool clr", 32'({fl.aux_ot, fl.block_ot}), 32'h0);
      sense.aux_hot = 1'b1;
      cyc(5);
      check("aux off hot", 32'(fl.block_ot), 32'h0);
      sense.aux_hot = 1'b0;
      sense.xcvr_uv = 1'b1;
      cyc(5);
      check("xcvr uv off", 32'(fl.xcvr_uv), 32'h0);
      xcvr_en = 1'b1;
      cyc(5);
      check("xcvr uv", 32'(fl.xcvr_uv), 32'h1);
      sense.xcvr_uv = 1'b0;
      cyc(3);
      cm = '0;
      cm.xcvr_uv = 1'b1;
      clear_now(cm);
      check("xcvr uv clr", 32'(fl.xcvr_uv), 32'h0);
      sense.xcvr_hot = 1'b1;
      cyc(5);
      check("tx off", 32'({tx_en, fl.xcvr_fault, fl.block_ot}), 32'h3);
      sense.xcvr_hot = 1'b0;
      cyc(5);
      check("tx back", 32'({tx_en, fl.xcvr_fault}), 32'h5);
      cm = '0;
      cm.xcvr_fault = 1'b1;
      cm.block_ot = 1'b1;
      clear_now(cm);
      check("xcvr clr", 32'({fl.xcvr_fault, fl.block_ot}), 32'h0);
      sense.prewarn_hot = 1'b1;
      cyc(5);
      cm = '0;
      cm.prewarn = 1'b1;
      clear_now(cm);
      check("prewarn", 32'(fl.prewarn), 32'h1);
      sense.prewarn_hot = 1'b0;
      cyc(4);
      clear_now(cm);
      check("prewarn clr", 32'(fl.prewarn), 32'h0);
      ext_en = 1'b1;
      cm = '0;
      cm.chip_ot = 1'b1;
      for (i = 1; i <= 16; i++) begin
         sense.chip_hot = 1'b1;
         cyc(5);
         check("chip mode", 32'(mode), 32'(stsv_pkg::STSV_FAILSAFE));
         check("event count", 32'(cnt), 32'(i));
         sense.chip_hot = 1'b0;
         if (i < 16) begin
            cyc(5);
            check("cool wait", 32'(mode), 32'(stsv_pkg::STSV_FAILSAFE));
            if (i == 1) clear_now(cm);
            check("chip flag", 32'(fl.chip_ot), 32'h1);
            wait_mode(stsv_pkg::STSV_NORMAL, 40);
         end
      end
      check("safe", 32'(fl.safe), 32'h1);
      cyc(200);
      check("long wait", 32'(mode), 32'(stsv_pkg::STSV_FAILSAFE));
      wait_mode(stsv_pkg::STSV_NORMAL, 800);
      clear_now(cm);
      check("chip clr", 32'({fl.chip_ot, cnt}), 32'h0);
      cm = '0;
      cm.safe = 1'b1;
      clear_now(cm);
      check("safe clr", 32'(fl.safe), 32'h0);
      sense.chip_hot = 1'b1;
      cyc(5);
      sense.chip_hot = 1'b0;
      wait_mode(stsv_pkg::STSV_NORMAL, 40);
      ext_en = 1'b0;
      cyc(3);
      check("ext clr", 32'(cnt), 32'h0);
      sense.chip_hot = 1'b1;
      sleep_req = 1'b1;
      cyc(1);
      sleep_req = 1'b0;
      wait_mode(stsv_pkg::STSV_FAILSAFE, 10);
      sense.chip_hot = 1'b0;
      wait_mode(stsv_pkg::STSV_NORMAL, 40);
      close_out();
   end
endmodule : tb_top
`default_nettype wire
